//--- logic/dcrdn_engine.sv
// Contract
// [R1] read is service 0x4F, class 0x432, instance 1, no attribute
// [R2] host sends 8 read bytes: timeout, connection, slot, index, max count
// [R3] slave wait bounded by request timeout in ms, then timeout status
// [R4] host carries the connection reference from the initialize exchange
// [R5] read answer: status, 3 ext, length, reserved, then length data bytes
// [R6] write is service 0x50, same class/instance, length 8 plus payload
// [R7] host write layout: timeout, connection, slot, index, count, payload
// [R8] write answer: status, 3 ext, bytes actually written
// [R9] status and ext status carry the fieldbus exchange outcome
// [R10] visible flag raised while new slave diagnostics wait
// [R11] one waiting bit per node 0..126, set while diagnostics wait
// [R12] extract in mode 1 clears that node's waiting bit
// [R13] initialize supplies the connection reference later requests carry
// [R14] malformed or unknown requests get error status, no fieldbus access
module dcrdn_engine #(
  parameter int MS_CYCLES = dcrdn_pkg::MS_CYCLES_DFLT
) (
  input  wire logic                       ref_clk,
  input  wire logic                       sys_rst,
  input  wire logic                       req_start,
  input  wire dcrdn_pkg::dcrdn_cip_hdr_t  req_hdr,
  input  wire logic                       req_byte_valid,
  input  wire logic [7:0]                 req_byte,
  input  wire logic                       conn_ref_set,
  input  wire logic [7:0]                 conn_ref_value,
  input  wire logic                       fb_rd_valid,
  input  wire logic [7:0]                 fb_rd_byte,
  input  wire logic                       fb_rsp_valid,
  input  wire dcrdn_pkg::dcrdn_fb_rsp_t   fb_rsp,
  input  wire logic                       diag_new_valid,
  input  wire logic [6:0]                 diag_new_node,
  input  wire logic                       diag_extract_valid,
  input  wire logic [6:0]                 diag_extract_node,
  input  wire logic [7:0]                 diag_extract_mode,
  output logic                            rsp_valid,
  output logic [7:0]                      rsp_byte,
  output logic                            rsp_last,
  output logic                            fb_req_valid,
  output dcrdn_pkg::dcrdn_fb_req_t        fb_req,
  output logic                            fb_wr_valid,
  output logic [7:0]                      fb_wr_byte,
  output logic [126:0]                    node_diag_waiting_bitmap,
  output logic                            diag_new_flag
);
  import dcrdn_pkg::*;

  dcrdn_state_t   st;
  dcrdn_cip_hdr_t hdr_q;
  logic [15:0]    rx_cnt;
  logic [31:0]    tmo_q;
  logic [7:0]     conn_ref;
  logic           conn_valid;
  logic [7:0]     slot_q;
  logic [7:0]     index_q;
  logic [7:0]     count_q;
  logic [7:0]     buf_mem [0:BUF_DEPTH-1];
  logic [7:0]     status_q;
  logic [23:0]    ext_q;
  logic [7:0]     len_q;
  logic [15:0]    rsp_total;
  logic [15:0]    out_cnt;
  logic [7:0]     io_cnt;
  logic [31:0]    div_cnt;
  logic [31:0]    ms_cnt;
  logic           ms_tick;
  logic           hdr_ok;
  logic           is_wr;
  logic           last_rx;
  logic           rx_bad;
  logic [7:0]     rx_code;
  logic [7:0]     cnt_now;
  logic [7:0]     rd_len;
  logic           tmo_hit;
  logic [7:0]     next_rsp_byte;
  logic [126:0]   next_bitmap;

  // header screening at request start
  assign hdr_ok = req_hdr.class_id == CLASS_ACYC && req_hdr.instance_id == INST_ACYC
                  && !req_hdr.attr_used
                  && ((req_hdr.service == SVC_READ && req_hdr.data_len == HDR_BYTES) // R1
                  || (req_hdr.service == SVC_WRITE && req_hdr.data_len >= HDR_BYTES)); // R6
  assign is_wr   = hdr_q.service == SVC_WRITE;
  assign last_rx = req_byte_valid && (rx_cnt == hdr_q.data_len - 16'h0001);
  assign cnt_now = (rx_cnt == OFS_COUNT) ? req_byte : count_q;
  assign rd_len  = (fb_rsp.length > count_q) ? count_q : fb_rsp.length;
  assign ms_tick = div_cnt == 32'(MS_CYCLES - 1);
  assign tmo_hit = ms_cnt >= tmo_q;

  // per-byte layout checks on the request body
  always_comb begin
    rx_bad  = 1'b0;
    rx_code = ST_BAD_REQ;
    if (rx_cnt == OFS_CONN && (!conn_valid || req_byte != conn_ref)) begin
      rx_bad  = 1'b1; // R13
      rx_code = ST_BAD_CONN;
    end
    if (rx_cnt == OFS_COUNT && is_wr && hdr_q.data_len != HDR_BYTES + {8'h00, req_byte}) begin
      rx_bad = 1'b1; // R6
    end
  end

  // connection reference handed over by the initialize exchange
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      conn_valid <= 1'b0;
      conn_ref   <= 8'h00;
    end else if (conn_ref_set) begin
      conn_valid <= 1'b1; // R13
      conn_ref   <= conn_ref_value;
    end
  end

  // request field capture and payload / read data buffer
  always_ff @(posedge ref_clk) begin
    if (st == ST_RX && req_byte_valid) begin
      if (rx_cnt < OFS_CONN) begin
        tmo_q <= {req_byte, tmo_q[31:8]};
      end
      if (rx_cnt == OFS_SLOT) begin
        slot_q <= req_byte;
      end
      if (rx_cnt == OFS_INDEX) begin
        index_q <= req_byte;
      end
      if (rx_cnt == OFS_COUNT) begin
        count_q <= req_byte;
      end
      if (rx_cnt >= HDR_BYTES) begin
        buf_mem[8'(rx_cnt - HDR_BYTES)] <= req_byte;
      end
    end else if (st == ST_WAIT && fb_rd_valid && io_cnt < count_q) begin
      buf_mem[io_cnt] <= fb_rd_byte;
    end
  end

  // millisecond timebase, restarted when the fieldbus request goes out
  always_ff @(posedge ref_clk) begin
    if (sys_rst || st == ST_RX) begin
      div_cnt <= 32'h0000_0000;
      ms_cnt  <= 32'h0000_0000;
    end else if (st == ST_SEND || st == ST_WAIT) begin
      div_cnt <= ms_tick ? 32'h0000_0000 : div_cnt + 32'h0000_0001;
      if (ms_tick) begin
        ms_cnt <= ms_cnt + 32'h0000_0001;
      end
    end
  end

  // response byte selection
  always_comb begin
    unique case (out_cnt)
      RSP_STATUS: next_rsp_byte = status_q;
      RSP_EXT0:   next_rsp_byte = ext_q[7:0];
      RSP_EXT1:   next_rsp_byte = ext_q[15:8];
      RSP_EXT2:   next_rsp_byte = ext_q[23:16];
      RSP_LEN:    next_rsp_byte = len_q;
      RSP_RSVD:   next_rsp_byte = 8'h00;
      default:    next_rsp_byte = buf_mem[8'(out_cnt - RD_RSP_HDR)];
    endcase
  end

  // sequencing of one request from start to last answer byte
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st           <= ST_IDLE;
      hdr_q        <= '0;
      rx_cnt       <= 16'h0000;
      status_q     <= 8'h00;
      ext_q        <= 24'h00_0000;
      len_q        <= 8'h00;
      rsp_total    <= 16'h0000;
      out_cnt      <= 16'h0000;
      io_cnt       <= 8'h00;
      fb_req_valid <= 1'b0;
      fb_req       <= '0;
      fb_wr_valid  <= 1'b0;
      fb_wr_byte   <= 8'h00;
      rsp_valid    <= 1'b0;
      rsp_byte     <= 8'h00;
      rsp_last     <= 1'b0;
    end else begin
      fb_req_valid <= 1'b0;
      fb_wr_valid  <= 1'b0;
      rsp_valid    <= 1'b0;
      rsp_last     <= 1'b0;
      unique case (st)
        ST_IDLE: begin
          rx_cnt  <= 16'h0000;
          out_cnt <= 16'h0000;
          io_cnt  <= 8'h00;
          ext_q   <= 24'h00_0000;
          len_q   <= 8'h00;
          if (req_start) begin
            hdr_q <= req_hdr;
            if (hdr_ok) begin
              st <= ST_RX;
            end else begin
              status_q  <= ST_BAD_REQ; // R14
              rsp_total <= ERR_RSP_HDR;
              st        <= (req_hdr.data_len == 16'h0000) ? ST_RESP : ST_DRAIN;
            end
          end
        end
        ST_RX: begin
          if (req_byte_valid) begin
            rx_cnt <= rx_cnt + 16'h0001;
            if (rx_bad) begin
              status_q  <= rx_code; // R14
              rsp_total <= ERR_RSP_HDR;
              st        <= last_rx ? ST_RESP : ST_DRAIN;
            end else if (last_rx) begin
              fb_req_valid <= 1'b1;
              fb_req       <= '{is_write: is_wr, conn_ref: conn_ref, slot: slot_q,
                                index: index_q, count: cnt_now};
              st           <= (is_wr && cnt_now != 8'h00) ? ST_SEND : ST_WAIT;
            end
          end
        end
        ST_SEND: begin
          fb_wr_valid <= 1'b1;
          fb_wr_byte  <= buf_mem[io_cnt];
          io_cnt      <= io_cnt + 8'h01;
          if (io_cnt == count_q - 8'h01) begin
            io_cnt <= 8'h00;
            st     <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (fb_rd_valid && io_cnt < count_q) begin
            io_cnt <= io_cnt + 8'h01;
          end
          if (fb_rsp_valid) begin
            status_q  <= fb_rsp.status; // R9
            ext_q     <= fb_rsp.ext;
            len_q     <= is_wr ? fb_rsp.length : rd_len;
            rsp_total <= is_wr ? WR_RSP_HDR : RD_RSP_HDR + {8'h00, rd_len}; // R5 R8
            st        <= ST_RESP;
          end else if (tmo_hit) begin
            status_q  <= ST_TIMEOUT; // R3
            len_q     <= 8'h00;
            rsp_total <= is_wr ? WR_RSP_HDR : RD_RSP_HDR;
            st        <= ST_RESP;
          end
        end
        ST_DRAIN: begin
          if (req_byte_valid) begin
            rx_cnt <= rx_cnt + 16'h0001;
            if (last_rx) begin
              st <= ST_RESP;
            end
          end
        end
        ST_RESP: begin
          rsp_valid <= 1'b1;
          rsp_byte  <= next_rsp_byte;
          rsp_last  <= out_cnt == rsp_total - 16'h0001;
          out_cnt   <= out_cnt + 16'h0001;
          if (out_cnt == rsp_total - 16'h0001) begin
            st <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // waiting-diagnostics bit per node; a new arrival wins over a clear
  for (genvar g = 0; g < NODE_COUNT; g++) begin : g_node
    assign next_bitmap[g] = (diag_new_valid && diag_new_node == 7'(g)) ? 1'b1 : // R11
                            (diag_extract_valid && diag_extract_node == 7'(g)
                             && diag_extract_mode == MODE_READ_CLEAR) ? 1'b0 : // R12
                            node_diag_waiting_bitmap[g];
  end

  // bitmap and summary flag registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      node_diag_waiting_bitmap <= '0;
      diag_new_flag            <= 1'b0;
    end else begin
      node_diag_waiting_bitmap <= next_bitmap;
      diag_new_flag            <= |next_bitmap; // R10
    end
  end

  property p_read_req;
    @(posedge ref_clk) disable iff (sys_rst)
    fb_req_valid && !fb_req.is_write |-> hdr_q.service == SVC_READ && hdr_q.data_len == HDR_BYTES;
  endproperty
  a_read_req: assert property (p_read_req) else $error("read issued for bad header"); // R1

  property p_write_len;
    @(posedge ref_clk) disable iff (sys_rst)
    fb_req_valid && fb_req.is_write |-> hdr_q.data_len == HDR_BYTES + {8'h00, fb_req.count};
  endproperty
  a_write_len: assert property (p_write_len) else $error("write length mismatch"); // R6

  property p_timeout;
    @(posedge ref_clk) disable iff (sys_rst)
    st == ST_WAIT && !fb_rsp_valid && ms_cnt >= tmo_q |=> st == ST_RESP && status_q == ST_TIMEOUT;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not answered"); // R3

  property p_read_size;
    @(posedge ref_clk) disable iff (sys_rst)
    rsp_last && !is_wr && status_q != ST_BAD_REQ && status_q != ST_BAD_CONN
      |-> $past(out_cnt) == RD_RSP_HDR + {8'h00, len_q} - 16'h0001;
  endproperty
  a_read_size: assert property (p_read_size) else $error("read answer size wrong"); // R5

  property p_write_size;
    @(posedge ref_clk) disable iff (sys_rst)
    rsp_last && is_wr && status_q != ST_BAD_REQ && status_q != ST_BAD_CONN
      |-> $past(out_cnt) == WR_RSP_HDR - 16'h0001;
  endproperty
  a_write_size: assert property (p_write_size) else $error("write answer size wrong"); // R8

  property p_status;
    @(posedge ref_clk) disable iff (sys_rst)
    st == ST_WAIT && fb_rsp_valid |=> status_q == $past(fb_rsp.status) ##1 rsp_byte == status_q;
  endproperty
  a_status: assert property (p_status) else $error("slave status not reported"); // R9

  property p_diag_set;
    @(posedge ref_clk) disable iff (sys_rst)
    diag_new_valid |=> node_diag_waiting_bitmap[$past(diag_new_node)] && diag_new_flag;
  endproperty
  a_diag_set: assert property (p_diag_set) else $error("diag bit not set"); // R11

  property p_diag_clr;
    @(posedge ref_clk) disable iff (sys_rst)
    diag_extract_valid && diag_extract_mode == MODE_READ_CLEAR
      && !(diag_new_valid && diag_new_node == diag_extract_node)
      |=> !node_diag_waiting_bitmap[$past(diag_extract_node)];
  endproperty
  a_diag_clr: assert property (p_diag_clr) else $error("diag bit not cleared"); // R12

  property p_flag;
    @(posedge ref_clk) disable iff (sys_rst)
    diag_new_flag == (|node_diag_waiting_bitmap);
  endproperty
  a_flag: assert property (p_flag) else $error("flag disagrees with bitmap"); // R10

  property p_reject;
    @(posedge ref_clk) disable iff (sys_rst)
    st == ST_DRAIN |-> !fb_req_valid ##1 !fb_req_valid;
  endproperty
  a_reject: assert property (p_reject) else $error("fieldbus started for bad request"); // R14
endmodule // dcrdn_engine

//--- logic/dcrdn_pkg.sv
package dcrdn_pkg;
  // request recognition
  localparam logic [7:0]  SVC_READ    = 8'h4F;
  localparam logic [7:0]  SVC_WRITE   = 8'h50;
  localparam logic [15:0] CLASS_ACYC  = 16'h0432;
  localparam logic [7:0]  INST_ACYC   = 8'h01;
  localparam logic [15:0] HDR_BYTES   = 16'h0008;
  // request byte offsets (timeout occupies 0..3, little endian)
  localparam logic [15:0] OFS_CONN    = 16'h0004;
  localparam logic [15:0] OFS_SLOT    = 16'h0005;
  localparam logic [15:0] OFS_INDEX   = 16'h0006;
  localparam logic [15:0] OFS_COUNT   = 16'h0007;
  // response byte offsets and sizes
  localparam logic [15:0] RSP_STATUS  = 16'h0000;
  localparam logic [15:0] RSP_EXT0    = 16'h0001;
  localparam logic [15:0] RSP_EXT1    = 16'h0002;
  localparam logic [15:0] RSP_EXT2    = 16'h0003;
  localparam logic [15:0] RSP_LEN     = 16'h0004;
  localparam logic [15:0] RSP_RSVD    = 16'h0005;
  localparam logic [15:0] ERR_RSP_HDR = 16'h0004;
  localparam logic [15:0] WR_RSP_HDR  = 16'h0005;
  localparam logic [15:0] RD_RSP_HDR  = 16'h0006;
  // status codes raised by this block itself
  localparam logic [7:0]  ST_BAD_REQ  = 8'h01;
  localparam logic [7:0]  ST_TIMEOUT  = 8'h02;
  localparam logic [7:0]  ST_BAD_CONN = 8'h03;
  // diagnostics
  localparam int          NODE_COUNT  = 127;
  localparam logic [7:0]  MODE_READ_CLEAR = 8'h01;
  localparam int          BUF_DEPTH   = 256;
  // millisecond timebase
  localparam int          MS_NS        = 32'h000F_4240;
  localparam int          CLK_PERIOD_NS = 32'h0000_000A;
  localparam int          MS_CYCLES_DFLT = MS_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic [7:0]  service;
    logic [15:0] class_id;
    logic [7:0]  instance_id;
    logic        attr_used;
    logic [15:0] data_len;
  } dcrdn_cip_hdr_t;

  typedef struct packed {
    logic        is_write;
    logic [7:0]  conn_ref;
    logic [7:0]  slot;
    logic [7:0]  index;
    logic [7:0]  count;
  } dcrdn_fb_req_t;

  typedef struct packed {
    logic [7:0]  status;
    logic [23:0] ext;
    logic [7:0]  length;
  } dcrdn_fb_rsp_t;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b00_0001,
    ST_RX    = 6'b00_0010,
    ST_SEND  = 6'b00_0100,
    ST_WAIT  = 6'b00_1000,
    ST_DRAIN = 6'b01_0000,
    ST_RESP  = 6'b10_0000
  } dcrdn_state_t;
endpackage

//--- bench/dcrdn_slave_model.sv
module dcrdn_slave_model
  import dcrdn_pkg::*;
(
  input  wire logic                     ref_clk,
  input  wire logic                     mute,
  input  wire logic                     slow,
  input  wire logic                     fb_req_valid,
  input  wire dcrdn_pkg::dcrdn_fb_req_t fb_req,
  input  wire logic                     fb_wr_valid,
  output logic                          fb_rd_valid,
  output logic [7:0]                    fb_rd_byte,
  output logic                          fb_rsp_valid,
  output dcrdn_pkg::dcrdn_fb_rsp_t      fb_rsp
);
  timeunit 1ns;
  timeprecision 100ps;
  dcrdn_fb_req_t req;
  int            n;
  // quiet lines until the first exchange, then one exchange per request on
  // falling edges; a muted slave never answers
  initial begin
    fb_rd_valid  = 1'b0;
    fb_rd_byte   = 8'h00;
    fb_rsp_valid = 1'b0;
    fb_rsp       = '0;
    forever begin
      @(posedge ref_clk iff fb_req_valid);
      req = fb_req;
      n = 0;
      // payload comes back to back after the request
      while (req.is_write && n < int'(req.count)) begin
        @(posedge ref_clk);
        if (fb_wr_valid) n++;
      end
      repeat (slow ? 40 : 1) @(negedge ref_clk);
      // read data ahead of the status, one byte more than asked for
      if (!mute && !req.is_write) begin
        fb_rd_valid = 1'b1;
        for (n = 0; n <= int'(req.count); n++) begin
          fb_rd_byte = 8'hC0 + 8'(n);
          @(negedge ref_clk);
        end
        fb_rd_valid = 1'b0;
        fb_rd_byte  = ~fb_rd_byte; // no stale data once released
      end
      // outcome tied to the forwarded slot and index
      if (!mute) begin
        fb_rsp_valid = 1'b1;
        fb_rsp = '{8'h00, {req.slot, req.index, 8'h5A}, req.count + 8'(!req.is_write)};
        @(negedge ref_clk);
        fb_rsp_valid = 1'b0;
        fb_rsp       = ~fb_rsp;
      end
    end
  end
endmodule // dcrdn_slave_model

//--- bench/dcrdn_engine_bench.sv
module dcrdn_engine_bench
  import dcrdn_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int MS = 10;
  logic ref_clk = 1'b0, sys_rst = 1'b1, mute = 1'b0, slow = 1'b0;
  logic req_start = 1'b0, req_byte_valid = 1'b0, conn_ref_set = 1'b0;
  logic [7:0] req_byte = 8'h00, conn_ref_value = 8'h00, diag_extract_mode = 8'h00;
  logic diag_new_valid = 1'b0, diag_extract_valid = 1'b0;
  logic [6:0] diag_new_node = 7'h00, diag_extract_node = 7'h00;
  dcrdn_cip_hdr_t req_hdr = '0;
  logic fb_rd_valid, fb_rsp_valid, rsp_valid, rsp_last, fb_req_valid, fb_wr_valid;
  logic [7:0] fb_rd_byte, rsp_byte, fb_wr_byte;
  dcrdn_fb_rsp_t fb_rsp;
  dcrdn_fb_req_t fb_req;
  logic [126:0] node_diag_waiting_bitmap;
  logic diag_new_flag;
  logic [7:0] rsp_q[$], wr_q[$];
  int cyc = 0, nreq = 0, req_cyc = 0, rsp_cyc = 0, checks = 0, miscompares = 0;

  dcrdn_engine #(.MS_CYCLES(MS)) u_dcrdn_engine (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .req_start(req_start), .req_hdr(req_hdr), .req_byte_valid(req_byte_valid),
    .req_byte(req_byte), .conn_ref_set(conn_ref_set), .conn_ref_value(conn_ref_value),
    .fb_rd_valid(fb_rd_valid), .fb_rd_byte(fb_rd_byte), .fb_rsp_valid(fb_rsp_valid),
    .fb_rsp(fb_rsp), .diag_new_valid(diag_new_valid), .diag_new_node(diag_new_node),
    .diag_extract_valid(diag_extract_valid), .diag_extract_node(diag_extract_node),
    .diag_extract_mode(diag_extract_mode), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte),
    .rsp_last(rsp_last), .fb_req_valid(fb_req_valid), .fb_req(fb_req),
    .fb_wr_valid(fb_wr_valid), .fb_wr_byte(fb_wr_byte),
    .node_diag_waiting_bitmap(node_diag_waiting_bitmap), .diag_new_flag(diag_new_flag));

  dcrdn_slave_model u_dcrdn_slave_model (.ref_clk(ref_clk), .mute(mute), .slow(slow),
    .fb_req_valid(fb_req_valid), .fb_req(fb_req), .fb_wr_valid(fb_wr_valid),
    .fb_rd_valid(fb_rd_valid), .fb_rd_byte(fb_rd_byte), .fb_rsp_valid(fb_rsp_valid),
    .fb_rsp(fb_rsp));

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  // collect answer bytes, payload bytes and request timing
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (rsp_valid && rsp_q.size() == 0) rsp_cyc <= cyc;
    if (rsp_valid) rsp_q.push_back(rsp_byte);
    if (fb_wr_valid) wr_q.push_back(fb_wr_byte);
    if (fb_req_valid) req_cyc <= cyc;
    if (req_start) nreq <= 0;
    else if (fb_req_valid) nreq <= nreq + 1;
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk127(input logic [126:0] got, input logic [126:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rsp(input logic [7:0] e[$]);
    chk8(8'(rsp_q.size()), 8'(e.size()));
    foreach (e[i]) chk8(rsp_q[i], e[i]);
  endtask

  function automatic dcrdn_cip_hdr_t hdr(input logic [7:0] s, input int n);
    return '{s, CLASS_ACYC, INST_ACYC, 1'b0, 16'(n)};
  endfunction

  // one request: header, body bytes, then wait for the final answer byte
  task automatic send(input dcrdn_cip_hdr_t h, input logic [7:0] body[$]);
    int w;
    rsp_q.delete();
    wr_q.delete();
    @(negedge ref_clk);
    req_hdr = h;
    req_start = 1'b1;
    foreach (body[i]) begin
      @(negedge ref_clk);
      req_start = 1'b0;
      req_byte_valid = 1'b1;
      req_byte = body[i];
    end
    @(negedge ref_clk);
    req_start = 1'b0;
    req_byte_valid = 1'b0;
    for (w = 0; w < 3000 && !(rsp_valid && rsp_last); w++) @(negedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic t_noconn;
    send(hdr(SVC_READ, 8), '{8'hE8, 8'h03, 8'h00, 8'h00, 8'h3C, 8'h02, 8'h07, 8'h04});
    chk_rsp('{ST_BAD_CONN, 8'h00, 8'h00, 8'h00});
    chk8(8'(nreq), 8'h00);
    @(negedge ref_clk);
    conn_ref_set = 1'b1;
    conn_ref_value = 8'h3C;
    @(negedge ref_clk);
    conn_ref_set = 1'b0;
  endtask

  task automatic t_read;
    slow = 1'b1;
    send(hdr(SVC_READ, 8), '{8'hE8, 8'h03, 8'h00, 8'h00, 8'h3C, 8'h02, 8'h07, 8'h04});
    chk_rsp('{8'h00, 8'h5A, 8'h07, 8'h02, 8'h04, 8'h00, 8'hC0, 8'hC1, 8'hC2, 8'hC3});
    chk8(8'(nreq), 8'h01);
    chk8(fb_req.slot, 8'h02);
    chk8(fb_req.index, 8'h07);
    chk8(fb_req.count, 8'h04);
    chk8(fb_req.conn_ref, 8'h3C);
    chk8(8'(fb_req.is_write), 8'h00);
  endtask

  task automatic t_write;
    slow = 1'b0;
    send(hdr(SVC_WRITE, 11), '{8'hE8, 8'h03, 8'h00, 8'h00, 8'h3C, 8'h02, 8'h07, 8'h03,
                               8'h11, 8'h22, 8'h33});
    chk_rsp('{8'h00, 8'h5A, 8'h07, 8'h02, 8'h03});
    chk8(8'(wr_q.size()), 8'h03);
    chk8(fb_req.count, 8'h03);
    chk8(wr_q[0], 8'h11);
    chk8(wr_q[1], 8'h22);
    chk8(wr_q[2], 8'h33);
    chk8(8'(fb_req.is_write), 8'h01);
  endtask

  // malformed headers, wrong length and wrong connection are all refused
  task automatic t_bad;
    dcrdn_cip_hdr_t h[7];
    logic [7:0] b[$];
    b = '{8'hE8, 8'h03, 8'h00, 8'h00, 8'h3C, 8'h02, 8'h07, 8'h03, 8'h11, 8'h22};
    h[0] = hdr(SVC_READ, 7);
    h[1] = hdr(SVC_WRITE, 10);
    h[2] = hdr(8'h4E, 8);
    h[3] = hdr(SVC_READ, 8);
    h[3].class_id = 16'h0433;
    h[4] = hdr(SVC_READ, 8);
    h[4].instance_id = 8'h02;
    h[5] = hdr(SVC_READ, 8);
    h[5].attr_used = 1'b1;
    h[6] = hdr(SVC_WRITE, 0);
    foreach (h[i]) begin
      send(h[i], b[0:int'(h[i].data_len)-1]);
      chk_rsp('{ST_BAD_REQ, 8'h00, 8'h00, 8'h00});
      chk8(8'(nreq), 8'h00);
    end
    b[4] = 8'h3D;
    send(hdr(SVC_READ, 8), b[0:7]);
    chk_rsp('{ST_BAD_CONN, 8'h00, 8'h00, 8'h00});
  endtask

  task automatic t_timeout;
    mute = 1'b1;
    send(hdr(SVC_READ, 8), '{8'h01, 8'h00, 8'h00, 8'h00, 8'h3C, 8'h02, 8'h07, 8'h04});
    chk_rsp('{ST_TIMEOUT, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    chk8(8'(rsp_cyc - req_cyc >= MS && rsp_cyc - req_cyc <= MS + 6), 8'h01);
    mute = 1'b0;
  endtask

  // one cycle of diagnostics arrival and extraction
  task automatic diag(input logic nv, input logic [6:0] nn, input logic ev,
                      input logic [6:0] en, input logic [7:0] md);
    @(negedge ref_clk);
    diag_new_valid = nv;
    diag_new_node = nn;
    diag_extract_valid = ev;
    diag_extract_node = en;
    diag_extract_mode = md;
    @(negedge ref_clk);
    diag_new_valid = 1'b0;
    diag_extract_valid = 1'b0;
  endtask

  task automatic t_diag;
    logic [126:0] m;
    m = {1'b1, 125'h0, 1'b1};
    diag(1'b1, 7'd126, 1'b0, 7'd0, 8'h00);
    diag(1'b1, 7'd0, 1'b1, 7'd126, 8'h00);
    chk127(node_diag_waiting_bitmap, m);
    chk8(8'(diag_new_flag), 8'h01);
    diag(1'b0, 7'd0, 1'b1, 7'd126, 8'h02);
    chk127(node_diag_waiting_bitmap, m);
    diag(1'b1, 7'd0, 1'b1, 7'd0, MODE_READ_CLEAR);
    chk127(node_diag_waiting_bitmap, m);
    diag(1'b0, 7'd0, 1'b1, 7'd126, MODE_READ_CLEAR);
    chk127(node_diag_waiting_bitmap, 127'h1);
    diag(1'b0, 7'd0, 1'b1, 7'd0, MODE_READ_CLEAR);
    chk127(node_diag_waiting_bitmap, 127'h0);
    chk8(8'(diag_new_flag), 8'h00);
  endtask

  task automatic results;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // reset, then each scenario in turn
  initial begin
    repeat (4) @(negedge ref_clk);
    sys_rst = 1'b0;
    chk127(node_diag_waiting_bitmap, 127'h0);
    t_noconn();
    t_read();
    t_write();
    t_bad();
    t_timeout();
    t_diag();
    results();
  end

  // cut a hang short
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    results();
  end
endmodule // dcrdn_engine_bench
